// *** rtl/enc_pos_pkg.sv ***
package enc_pos_pkg;
  // ==========================================
  // object indices
  localparam logic [15:0] IDX_MFR_OFFSET = 16'h2001;
  localparam logic [15:0] IDX_OP_PARAMS = 16'h6000;
  localparam logic [15:0] IDX_STEPS_REV = 16'h6001;
  localparam logic [15:0] IDX_TOTAL_STEPS = 16'h6002;
  localparam logic [15:0] IDX_PRESET = 16'h6003;
  localparam logic [15:0] IDX_POSITION = 16'h6004;
  localparam logic [15:0] IDX_CYCLIC_TIMER = 16'h6200;
  localparam logic [15:0] IDX_OP_STATUS = 16'h6500;
  localparam logic [15:0] IDX_PHYS_RES = 16'h6501;
  localparam logic [15:0] IDX_OFFSET = 16'h6509;
  localparam logic [15:0] IDX_MFR_OFFSET_RO = 16'h650a;
  // ==========================================
  // operating parameter fields
  localparam int OP_DIR_BIT = 0;
  localparam int OP_HWCHK_BIT = 1;
  localparam int OP_SCALE_BIT = 2;
  localparam int OP_RESID_BIT = 12;
  localparam logic [15:0] OP_USED_MASK = 16'h1007;
  localparam logic [15:0] OP_PRESET_MASK = 16'h0005;
  localparam logic [15:0] OP_RESET = 16'h0000;
  // ==========================================
  // physical resolution of the code disc
  localparam int ST_BITS = 13;
  localparam int MT_BITS = 12;
  localparam int POS_BITS = ST_BITS + MT_BITS;
  localparam logic [31:0] PHYS_RES = 32'h0000_2000;
  localparam logic [31:0] PHYS_TOTAL = 32'h0200_0000;
  localparam logic [31:0] PRESET_DELETE = 32'hffff_ffff;
  // dividend: scaled position plus residual, one guard bit
  localparam int DVD_BITS = POS_BITS + 32 - ST_BITS + 1;
  localparam logic [5:0] DVD_LAST = 6'(DVD_BITS - 1);
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_NS = 1000000;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  // ==========================================
  // position pipeline states
  typedef enum logic [2:0] {
    ST_LOAD = 3'b001,
    ST_DIV = 3'b010,
    ST_ADJ = 3'b100
  } pos_state_t;
endpackage

// *** rtl/encoder_position_scaling.sv ***
module encoder_position_scaling #(
  parameter int unsigned P_CYCLES_PER_MS = enc_pos_pkg::CYCLES_PER_MS
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_obj_wr,
  input wire logic i_obj_rd,
  input wire logic [15:0] i_obj_index,
  input wire logic [31:0] i_obj_wdata,
  input wire logic i_encoder_reset,
  input wire logic [enc_pos_pkg::POS_BITS-1:0] i_phys_pos,
  output logic [31:0] o_obj_rdata,
  output logic o_obj_done,
  output logic o_obj_abort,
  output logic [31:0] o_position,
  output logic o_hw_check_en,
  output logic o_resid_active,
  output logic o_pdo1_valid,
  output logic [31:0] o_pdo1_data,
  output logic o_nvm_save,
  output logic [31:0] o_nvm_residual
);
  import enc_pos_pkg::*;

  // ==========================================
  // state
  logic [15:0] op_r; // programmed operating parameters
  logic resid_active_r; // residual mode in force
  logic [31:0] steps_r; // steps per revolution
  logic [31:0] total_r; // total measuring steps
  logic [31:0] preset_r; // last accepted preset
  logic signed [31:0] offset_r; // preset-derived offset
  logic signed [31:0] mfr_offset_r; // manufacturer offset
  logic [15:0] timer_r; // cycle time in ms
  logic [31:0] pos_r; // published position
  logic [31:0] residual_r; // residual carried across wraps
  logic [31:0] span_mod_r; // one physical span mod total
  logic span_dirty_r; // span_mod_r needs recompute
  logic [1:0] prev_top_r; // top bits of last sample
  pos_state_t state_r;
  logic span_pass_r; // current division is the span
  logic [31:0] divisor_r;
  logic [31:0] rem_r;
  logic [DVD_BITS-1:0] dvd_r;
  logic [5:0] bit_cnt_r;
  logic nvm_save_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic abort_r;
  logic [31:0] ms_cnt_r; // clock cycles within a ms
  logic [15:0] period_cnt_r; // ms within a cycle period
  logic pdo_valid_r;
  logic [31:0] pdo_data_r;

  // ==========================================
  // helpers
  // one correction step back into [0, t); callers keep
  // the argument within (-t, 2t)
  function automatic logic [31:0] wrap_fix(
    input logic signed [34:0] v,
    input logic [31:0] t
  );
    logic signed [34:0] ts;
    ts = signed'({3'b000, t});
    if (v < 0) begin
      return 32'(v + ts);
    end else if (v >= ts) begin
      return 32'(v - ts);
    end
    return 32'(v);
  endfunction

  // ==========================================
  // effective scaling
  logic [31:0] scale_ratio_num; // numerator of scale_ratio
  logic [31:0] eff_total; // wrap point of the output
  logic [POS_BITS-1:0] phys_dir; // direction-corrected raw
  logic [POS_BITS+31:0] product;
  logic [DVD_BITS-1:0] dividend;
  logic [DVD_BITS-1:0] span_full;
  logic [1:0] cur_top;
  logic cross_fwd;
  logic cross_bwd;

  // bypass hands the raw position through unscaled
  assign scale_ratio_num = op_r[OP_SCALE_BIT] ? steps_r : PHYS_RES;
  assign eff_total = op_r[OP_SCALE_BIT] ? total_r : PHYS_TOTAL;
  // ccw counting is the mirror image of the disc code
  assign phys_dir = op_r[OP_DIR_BIT] ? ~i_phys_pos : i_phys_pos;
  // divide by a power-of-two resolution is a shift
  assign product = (POS_BITS+32)'(phys_dir) *
                   (POS_BITS+32)'(scale_ratio_num);
  assign dividend = DVD_BITS'(product[POS_BITS+31:ST_BITS]) +
                    (resid_active_r ? DVD_BITS'(residual_r)
                                    : DVD_BITS'(0));
  // scaled length of the full physical range
  assign span_full = DVD_BITS'({scale_ratio_num, {MT_BITS{1'b0}}});
  assign cur_top = phys_dir[POS_BITS-1 -: 2];
  assign cross_fwd = (prev_top_r == 2'b11) && (cur_top == 2'b00);
  assign cross_bwd = (prev_top_r == 2'b00) && (cur_top == 2'b11);

  // ==========================================
  // object write decode
  logic wr_ok; // write accepted
  logic clr_preset; // write wipes the preset
  logic cfg_change; // write alters the span
  always_comb begin
    wr_ok = 1'b0;
    clr_preset = 1'b0;
    cfg_change = 1'b0;
    case (i_obj_index)
      IDX_OP_PARAMS: begin
        wr_ok = 1'b1;
        clr_preset = |((i_obj_wdata[15:0] ^ op_r) &
                       OP_PRESET_MASK);
        cfg_change = 1'b1;
      end
      IDX_STEPS_REV: begin
        wr_ok = (i_obj_wdata <= PHYS_RES);
        clr_preset = (i_obj_wdata != steps_r);
        cfg_change = 1'b1;
      end
      IDX_TOTAL_STEPS: begin
        wr_ok = (i_obj_wdata <= PHYS_TOTAL);
        clr_preset = (i_obj_wdata != total_r);
        cfg_change = 1'b1;
      end
      IDX_PRESET: begin
        wr_ok = (i_obj_wdata == PRESET_DELETE) ||
                (i_obj_wdata <= eff_total);
      end
      IDX_CYCLIC_TIMER: begin
        wr_ok = 1'b1; // full 16-bit range, upper bits dropped
      end
      IDX_MFR_OFFSET: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = 1'b0; // read-only or unmapped
      end
    endcase
  end

  logic do_wr;
  assign do_wr = i_obj_wr && wr_ok;

  // ==========================================
  // object read mux
  logic rd_ok;
  logic [31:0] rd_val;
  always_comb begin
    rd_ok = 1'b1;
    rd_val = 32'h0000_0000;
    case (i_obj_index)
      IDX_OP_PARAMS: rd_val = {16'h0000, op_r};
      IDX_STEPS_REV: rd_val = steps_r;
      IDX_TOTAL_STEPS: rd_val = total_r;
      IDX_PRESET: rd_val = preset_r;
      IDX_POSITION: rd_val = pos_r;
      IDX_CYCLIC_TIMER: rd_val = {16'h0000, timer_r};
      IDX_OP_STATUS: rd_val = {16'h0000, op_r};
      IDX_PHYS_RES: rd_val = PHYS_RES;
      IDX_OFFSET: rd_val = offset_r;
      IDX_MFR_OFFSET, IDX_MFR_OFFSET_RO: rd_val = mfr_offset_r;
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================
  // object answer, one cycle after the strobe
  // a write strobe wins when both strobes arrive together
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      done_r <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      done_r <= i_obj_wr || i_obj_rd;
      if (i_obj_wr) begin
        abort_r <= !wr_ok;
        rdata_r <= 32'h0000_0000;
      end else if (i_obj_rd) begin
        abort_r <= !rd_ok;
        rdata_r <= rd_val;
      end else begin
        abort_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // configuration objects
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      op_r <= OP_RESET;
      steps_r <= PHYS_RES;
      total_r <= PHYS_TOTAL;
      preset_r <= 32'h0000_0000;
      offset_r <= 32'sh0000_0000;
      mfr_offset_r <= 32'sh0000_0000;
      timer_r <= 16'h0000;
    end else if (do_wr) begin
      case (i_obj_index)
        IDX_OP_PARAMS: op_r <= i_obj_wdata[15:0] & OP_USED_MASK;
        IDX_STEPS_REV: steps_r <= i_obj_wdata;
        IDX_TOTAL_STEPS: total_r <= i_obj_wdata;
        IDX_CYCLIC_TIMER: timer_r <= i_obj_wdata[15:0];
        IDX_MFR_OFFSET: mfr_offset_r <= i_obj_wdata;
        default: begin
        end
      endcase
      if (i_obj_index == IDX_PRESET) begin
        if (i_obj_wdata == PRESET_DELETE) begin
          preset_r <= 32'h0000_0000;
          offset_r <= 32'sh0000_0000;
        end else begin
          // shift the shown position onto the preset
          preset_r <= i_obj_wdata;
          offset_r <= offset_r + signed'(i_obj_wdata) -
                      signed'(pos_r);
        end
      end else if (clr_preset) begin
        preset_r <= 32'h0000_0000;
        offset_r <= 32'sh0000_0000;
      end
    end
  end

  // ==========================================
  // residual mode: the bit only lands on an encoder reset
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      resid_active_r <= 1'b0;
    end else if (i_encoder_reset) begin
      resid_active_r <= op_r[OP_RESID_BIT];
    end
  end

  // ==========================================
  // position pipeline: load, modulo by shifting, adjust
  // ~47 cycles per update trades latency for one small
  // subtractor instead of a full-width divider
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r <= ST_LOAD;
      span_pass_r <= 1'b0;
      divisor_r <= 32'h0000_0000;
      rem_r <= 32'h0000_0000;
      dvd_r <= '0;
      bit_cnt_r <= 6'h00;
      pos_r <= 32'h0000_0000;
      span_dirty_r <= 1'b1;
    end else begin
      case (state_r)
        ST_LOAD: begin
          divisor_r <= eff_total;
          rem_r <= 32'h0000_0000;
          bit_cnt_r <= 6'h00;
          span_pass_r <= span_dirty_r;
          dvd_r <= span_dirty_r ? span_full : dividend;
          state_r <= ST_DIV;
        end
        ST_DIV: begin
          // restoring step, remainder only
          if ({rem_r, dvd_r[DVD_BITS-1]} >= {1'b0, divisor_r}) begin
            rem_r <= 32'({rem_r, dvd_r[DVD_BITS-1]} -
                         {1'b0, divisor_r});
          end else begin
            rem_r <= {rem_r[30:0], dvd_r[DVD_BITS-1]};
          end
          dvd_r <= {dvd_r[DVD_BITS-2:0], 1'b0};
          bit_cnt_r <= bit_cnt_r + 6'h01;
          if (bit_cnt_r == DVD_LAST) begin
            state_r <= ST_ADJ;
          end
        end
        ST_ADJ: begin
          if (!span_pass_r) begin
            // a zero total leaves no room: hold at zero
            if (divisor_r == 32'h0000_0000) begin
              pos_r <= 32'h0000_0000;
            end else begin
              pos_r <= wrap_fix(35'(rem_r) + 35'(offset_r) +
                                35'(mfr_offset_r),
                                divisor_r);
            end
          end
          state_r <= ST_LOAD;
        end
        default: begin
          state_r <= ST_LOAD;
        end
      endcase
      // a fresh change beats the clear of the finished pass
      if (do_wr && cfg_change) begin
        span_dirty_r <= 1'b1;
      end else if (state_r == ST_ADJ && span_pass_r) begin
        span_dirty_r <= 1'b0;
      end
    end
  end

  // span result is taken straight from the divider
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      span_mod_r <= 32'h0000_0000;
    end else if (state_r == ST_ADJ && span_pass_r) begin
      span_mod_r <= (divisor_r == 32'h0000_0000) ? 32'h0000_0000
                                                 : rem_r;
    end
  end

  // ==========================================
  // residual bookkeeping at physical zero crossings
  // sampled once per pass, so the shaft must not sweep a
  // quarter of the range within one pass
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      prev_top_r <= 2'b00;
      residual_r <= 32'h0000_0000;
      nvm_save_r <= 1'b0;
    end else begin
      nvm_save_r <= 1'b0;
      if (state_r == ST_LOAD) begin
        prev_top_r <= cur_top;
        if (resid_active_r && cross_fwd) begin
          residual_r <= wrap_fix(35'(residual_r) + 35'(span_mod_r),
                                 eff_total);
          nvm_save_r <= 1'b1;
        end else if (resid_active_r && cross_bwd) begin
          residual_r <= wrap_fix(35'(residual_r) - 35'(span_mod_r),
                                 eff_total);
          nvm_save_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // transmission pacing for the first process data object
  logic timer_kick; // zero to nonzero write
  logic ms_tick;
  assign timer_kick = do_wr && (i_obj_index == IDX_CYCLIC_TIMER) &&
                      (timer_r == 16'h0000) &&
                      (i_obj_wdata[15:0] != 16'h0000);
  assign ms_tick = (ms_cnt_r == 32'(P_CYCLES_PER_MS - 1));

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ms_cnt_r <= 32'h0000_0000;
      period_cnt_r <= 16'h0000;
    end else if (timer_r == 16'h0000 || timer_kick) begin
      ms_cnt_r <= 32'h0000_0000;
      period_cnt_r <= 16'h0000;
    end else if (ms_tick) begin
      ms_cnt_r <= 32'h0000_0000;
      if (period_cnt_r + 16'h0001 >= timer_r) begin
        period_cnt_r <= 16'h0000;
      end else begin
        period_cnt_r <= period_cnt_r + 16'h0001;
      end
    end else begin
      ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
    end
  end

  logic period_end;
  assign period_end = (timer_r != 16'h0000) && ms_tick &&
                      (period_cnt_r + 16'h0001 >= timer_r);

  // timer zero means send whenever the position moves
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pdo_valid_r <= 1'b0;
      pdo_data_r <= 32'h0000_0000;
    end else begin
      pdo_valid_r <= 1'b0;
      if (timer_kick || period_end) begin
        pdo_valid_r <= 1'b1;
        pdo_data_r <= pos_r;
      end else if (timer_r == 16'h0000 && pos_r != pdo_data_r) begin
        pdo_valid_r <= 1'b1;
        pdo_data_r <= pos_r;
      end
    end
  end

  // ==========================================
  // outputs; byte 0 of each word is bits 7..0
  assign o_obj_rdata = rdata_r;
  assign o_obj_done = done_r;
  assign o_obj_abort = abort_r;
  assign o_position = pos_r;
  assign o_hw_check_en = op_r[OP_HWCHK_BIT];
  assign o_resid_active = resid_active_r;
  assign o_pdo1_valid = pdo_valid_r;
  assign o_pdo1_data = pdo_data_r;
  assign o_nvm_save = nvm_save_r;
  assign o_nvm_residual = residual_r;
endmodule

// *** dv/encoder_position_scaling_asserts.sv ***
// ==========================================
// port-level checker for the position block
module encoder_position_scaling_asserts
  import enc_pos_pkg::*;
#(
  parameter int unsigned P_CYCLES_PER_MS = 10
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_obj_wr,
  input wire logic i_obj_rd,
  input wire logic [15:0] i_obj_index,
  input wire logic [31:0] i_obj_wdata,
  input wire logic i_encoder_reset,
  input wire logic [enc_pos_pkg::POS_BITS-1:0] i_phys_pos,
  input wire logic [31:0] o_obj_rdata,
  input wire logic o_obj_done,
  input wire logic o_obj_abort,
  input wire logic [31:0] o_position,
  input wire logic o_hw_check_en,
  input wire logic o_resid_active,
  input wire logic o_pdo1_valid,
  input wire logic [31:0] o_pdo1_data,
  input wire logic o_nvm_save,
  input wire logic [31:0] o_nvm_residual
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // decoded requests; a write wins when both strobes are high
  wire logic rd_q = i_obj_rd && !i_obj_wr;
  wire logic wr_steps = i_obj_wr && i_obj_index == IDX_STEPS_REV;
  wire logic wr_total = i_obj_wr && i_obj_index == IDX_TOTAL_STEPS;
  wire logic hw_set = i_obj_wr && i_obj_index == IDX_OP_PARAMS &&
    i_obj_wdata[OP_HWCHK_BIT];
  // ==========================================
  // object access
  chk_every_request: assert property ((i_obj_wr || i_obj_rd) |=>
    o_obj_done) else $error("request not answered");
  chk_no_spurious: assert property (!(i_obj_wr || i_obj_rd) |=>
    !o_obj_done && !o_obj_abort) else $error("answer without request");
  chk_pos_readout: assert property ((rd_q && i_obj_index == IDX_POSITION)
    |=> !o_obj_abort && o_obj_rdata == $past(o_position))
    else $error("position read differs from output");
  chk_pos_readonly: assert property ((i_obj_wr &&
    i_obj_index == IDX_POSITION) |=> o_obj_abort)
    else $error("position write accepted");
  chk_steps_range: assert property (wr_steps |=>
    o_obj_abort == $past(i_obj_wdata > PHYS_RES))
    else $error("steps range check wrong");
  chk_total_range: assert property ((wr_total &&
    i_obj_wdata > PHYS_TOTAL) |=> o_obj_abort)
    else $error("total above range accepted");
  chk_status_unused: assert property ((rd_q &&
    i_obj_index == IDX_OP_STATUS) |=>
    (o_obj_rdata & {16'h0000, OP_USED_MASK}) == o_obj_rdata)
    else $error("unused status bits set");
  chk_phys_res: assert property ((rd_q && i_obj_index == IDX_PHYS_RES)
    |=> o_obj_rdata == PHYS_RES && !o_obj_abort)
    else $error("resolution readout wrong");
  // ==========================================
  // mode outputs and pacing
  chk_hwchk_write: assert property ($rose(o_hw_check_en) |->
    $past(hw_set) || $past(hw_set, 2))
    else $error("check enable rose without write");
  chk_resid_arm: assert property ($rose(o_resid_active) |->
    $past(i_encoder_reset)) else $error("residual mode armed early");
  chk_nvm_mode: assert property (o_nvm_save |-> o_resid_active)
    else $error("residual saved outside residual mode");
  chk_pos_pacing: assert property ($changed(o_position) |=>
    $stable(o_position)[*8]) else $error("position changed mid pass");
  chk_pdo_single: assert property (o_pdo1_valid |=> !o_pdo1_valid)
    else $error("send pulse longer than one cycle");
  // main scenarios reached
  cov_pdo: cover property (o_pdo1_valid);
  cov_nvm: cover property (o_nvm_save);
  cov_abort: cover property (o_obj_done && o_obj_abort);
  cov_resid: cover property ($rose(o_resid_active));
endmodule

bind encoder_position_scaling encoder_position_scaling_asserts #(
  .P_CYCLES_PER_MS(P_CYCLES_PER_MS)
) u_encoder_position_scaling_asserts (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_obj_wr(i_obj_wr),
  .i_obj_rd(i_obj_rd), .i_obj_index(i_obj_index),
  .i_obj_wdata(i_obj_wdata), .i_encoder_reset(i_encoder_reset),
  .i_phys_pos(i_phys_pos), .o_obj_rdata(o_obj_rdata),
  .o_obj_done(o_obj_done), .o_obj_abort(o_obj_abort),
  .o_position(o_position), .o_hw_check_en(o_hw_check_en),
  .o_resid_active(o_resid_active), .o_pdo1_valid(o_pdo1_valid),
  .o_pdo1_data(o_pdo1_data), .o_nvm_save(o_nvm_save),
  .o_nvm_residual(o_nvm_residual)
);

// *** dv/obj_master_model.sv ***
// ==========================================
// network master: object reads and writes
module obj_master_model (
  input wire logic i_clock,
  input wire logic i_obj_done,
  input wire logic i_obj_abort,
  input wire logic [31:0] i_obj_rdata,
  output logic o_obj_wr,
  output logic o_obj_rd,
  output logic [15:0] o_obj_index,
  output logic [31:0] o_obj_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    o_obj_wr = 1'b0;
    o_obj_rd = 1'b0;
    o_obj_index = 16'h0000;
    o_obj_wdata = 32'h0000_0000;
  end
  // one whole word per request, byte 0 in bits 7:0
  task automatic access(input logic wr, input logic [15:0] idx,
      input logic [31:0] data, output logic [31:0] rdata,
      output logic abort, output logic done);
    @(posedge i_clock);
    o_obj_wr <= wr;
    o_obj_rd <= ~wr;
    o_obj_index <= idx;
    o_obj_wdata <= data;
    @(posedge i_clock);
    // released lines show garbage so stale values cannot pass
    o_obj_wr <= 1'b0;
    o_obj_rd <= 1'b0;
    o_obj_index <= ~idx;
    o_obj_wdata <= ~data;
    #1;
    done = i_obj_done;
    abort = i_obj_abort;
    rdata = i_obj_rdata;
  endtask
endmodule

// *** dv/encoder_position_scaling_tb.sv ***
module encoder_position_scaling_tb;
  import enc_pos_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CPM = 10; // short millisecond for sim
  localparam logic [24:0] PH = 25'h0123456; // raw disc position
  logic clock = 1'b0;
  logic sys_rst, obj_wr, obj_rd, encoder_reset;
  logic [15:0] obj_index;
  logic [31:0] obj_wdata, obj_rdata, position, pdo1_data, nvm_residual;
  logic obj_done, obj_abort, hw_check_en, resid_active, pdo1_valid;
  logic nvm_save;
  logic [POS_BITS-1:0] phys_pos;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int cnt;
  always #2.5 clock = ~clock;
  encoder_position_scaling #(.P_CYCLES_PER_MS(CPM))
  u_encoder_position_scaling (
    .i_clock(clock), .i_sys_rst(sys_rst), .i_obj_wr(obj_wr),
    .i_obj_rd(obj_rd), .i_obj_index(obj_index), .i_obj_wdata(obj_wdata),
    .i_encoder_reset(encoder_reset), .i_phys_pos(phys_pos),
    .o_obj_rdata(obj_rdata), .o_obj_done(obj_done),
    .o_obj_abort(obj_abort), .o_position(position),
    .o_hw_check_en(hw_check_en), .o_resid_active(resid_active),
    .o_pdo1_valid(pdo1_valid), .o_pdo1_data(pdo1_data),
    .o_nvm_save(nvm_save), .o_nvm_residual(nvm_residual));
  obj_master_model u_obj_master_model (
    .i_clock(clock), .i_obj_done(obj_done), .i_obj_abort(obj_abort),
    .i_obj_rdata(obj_rdata), .o_obj_wr(obj_wr), .o_obj_rd(obj_rd),
    .o_obj_index(obj_index), .o_obj_wdata(obj_wdata));
  // ==========================================
  // helpers
  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // write; the answer flags must match the expected refusal
  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
      input logic ab);
    logic [31:0] r;
    logic a, dn;
    u_obj_master_model.access(1'b1, idx, d, r, a, dn);
    check({30'h0, dn, a}, {30'h0, 1'b1, ab});
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] exp,
      input logic ab);
    logic [31:0] r;
    logic a, dn;
    u_obj_master_model.access(1'b0, idx, 32'h0000_0000, r, a, dn);
    check({30'h0, dn, a}, {30'h0, 1'b1, ab});
    check(r, exp);
  endtask
  // bounded wait: a pass is 47 cycles, a config change costs two
  task automatic wait_pos(input logic [31:0] exp);
    for (int i = 0; i < 300 && position !== exp; i++) @(posedge clock);
    #1;
    check(position, exp);
  endtask
  // counts one-cycle pulses of the send or the save strobe
  task automatic count_pulses(input int n, input logic nvm);
    cnt = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      cnt += int'(nvm ? nvm_save : pdo1_valid);
    end
  endtask
  // hang guard, over ten times the cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    sys_rst = 1'b1;
    encoder_reset = 1'b0;
    phys_pos = PH;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    rd(IDX_OP_PARAMS, 32'h0, 1'b0);
    rd(IDX_STEPS_REV, PHYS_RES, 1'b0);
    rd(IDX_TOTAL_STEPS, PHYS_TOTAL, 1'b0);
    rd(IDX_PRESET, 32'h0, 1'b0);
    rd(IDX_CYCLIC_TIMER, 32'h0, 1'b0);
    rd(IDX_PHYS_RES, PHYS_RES, 1'b0);
    rd(16'h1234, 32'h0, 1'b1);
    wait_pos({7'h00, PH});
    rd(IDX_POSITION, {7'h00, PH}, 1'b0);
    // all bits set: only used ones stick, direction flips
    wr(IDX_OP_PARAMS, 32'h0000_ffff, 1'b0);
    rd(IDX_OP_STATUS, 32'h0000_1007, 1'b0);
    check({31'h0, hw_check_en}, 32'h1);
    check({31'h0, resid_active}, 32'h0);
    wait_pos(32'h01ff_ffff - {7'h00, PH});
    wr(IDX_OP_PARAMS, 32'h0, 1'b0);
    check({31'h0, hw_check_en}, 32'h0);
    // range refusals, then scaling bypassed while disabled
    wr(IDX_STEPS_REV, 32'h0000_1000, 1'b0);
    wr(IDX_STEPS_REV, 32'h0000_2001, 1'b1);
    wr(IDX_TOTAL_STEPS, 32'h0200_0001, 1'b1);
    wr(IDX_POSITION, 32'h0, 1'b1);
    wait_pos({7'h00, PH});
    wr(IDX_OP_PARAMS, 32'h0000_0004, 1'b0);
    wait_pos(32'h0009_1a2b);
    // total is sixteen turns of the programmed resolution
    wr(IDX_TOTAL_STEPS, 32'h0001_0000, 1'b0);
    wait_pos(32'h0000_1a2b);
    // preset as offset, refusal above total, delete command
    wr(IDX_PRESET, 32'h0001_0001, 1'b1);
    wr(IDX_PRESET, 32'h0000_0100, 1'b0);
    rd(IDX_OFFSET, 32'h0000_0100 - 32'h0000_1a2b, 1'b0);
    wait_pos(32'h0000_0100);
    wr(IDX_PRESET, 32'hffff_ffff, 1'b0);
    rd(IDX_OFFSET, 32'h0, 1'b0);
    wait_pos(32'h0000_1a2b);
    wr(IDX_PRESET, 32'h0000_0100, 1'b0);
    wr(IDX_STEPS_REV, 32'h0000_0800, 1'b0);
    rd(IDX_OFFSET, 32'h0, 1'b0);
    wait_pos(32'h0000_8d15);
    wr(IDX_PRESET, 32'h0000_0100, 1'b0);
    wr(IDX_OP_PARAMS, 32'h0000_0005, 1'b0);
    rd(IDX_OFFSET, 32'h0, 1'b0);
    wr(IDX_MFR_OFFSET, 32'h0000_0005, 1'b0);
    rd(IDX_MFR_OFFSET_RO, 32'h0000_0005, 1'b0);
    wait_pos(32'h0000_72ef);
    // timer from zero sends at once, then every two milliseconds
    // the short sim millisecond keeps the period above one bus transfer
    wr(IDX_CYCLIC_TIMER, 32'h0000_0002, 1'b0);
    check({31'h0, pdo1_valid}, 32'h1);
    check(pdo1_data, 32'h0000_72ef);
    count_pulses(70, 1'b0);
    check(cnt, 3);
    // send-on-change mode: the master runs the link fast enough
    wr(IDX_CYCLIC_TIMER, 32'h0, 1'b0);
    phys_pos <= PH + 25'h0000_100;
    count_pulses(150, 1'b0);
    check({31'h0, cnt != 0}, 32'h1);
    // residual mode waits for the encoder reset, then saves at zero
    wr(IDX_OP_PARAMS, 32'h0000_1004, 1'b0);
    check({31'h0, resid_active}, 32'h0);
    @(posedge clock);
    encoder_reset <= 1'b1;
    @(posedge clock);
    encoder_reset <= 1'b0;
    #1;
    check({31'h0, resid_active}, 32'h1);
    phys_pos <= 25'h1ff_ffff;
    repeat (100) @(posedge clock);
    phys_pos <= 25'h000_0000;
    count_pulses(120, 1'b1);
    check({31'h0, cnt != 0}, 32'h1);
    // whole physical span is a multiple of this total: no residual
    check(nvm_residual, 32'h0);
    report_and_stop();
  end
endmodule
